/* hw/id_segment_register_file.sv */
// Contract
// - Keep a 32-byte file of captured, formatted and expected ID bytes.
// - Access enable set blocks sequencer access; processor pointer selects the location.
// - Five-bit pointer selects which file byte the data port reaches.
// - Data port read returns the pointed byte; a write replaces it.
// - IDs are top-justified in their block, consecutive, with no gaps.
// - Active A, Active B, expected IDs start at 0, 12, 24; flags follow.
// - Expected ID at 24-27, LBA if block format, else C/C/H/S.
// - LBA width select picks four or three expected address bytes.
// - LBA bytes: 27 bits 7-0, 26 15-8, 25 23-16, 24 30-24.
// - Segmented: Active A ID at 0-3, segment counts at 8-15.
// - Segmented: Active B ID at 4-7, segment counts at 16-23.
// - Active A and B hold identical copies; held after an error.
// - Error field register write supplies the next sequencer store byte.
// - Segmented mode plus trigger bit starts the segmentation logic; skip needs skip enable and instruction end.
// - Segment sizes come from the counts captured into the file.
// - ECC generate bit enables the ECC generator.
// - ECC source chosen from gates, buffer source and read compare enable.
// - Skip target select 00, 01, 10 picks skip address one, two, three.
`timescale 1ns/10ps
`default_nettype none
module id_segment_register_file
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] busAddr,
   input wire logic [7:0] busWriteData,
   input wire logic busWrite,
   input wire logic busRead,
   output logic [7:0] busReadData,
   input wire logic segmented_sector_mode,
   input wire logic block_format_select,
   input wire logic lba_width_select,
   input wire logic seqWrite,
   input wire id_file_pkg::field_type seqField,
   input wire logic [2:0] seqIndex,
   input wire logic [7:0] seqData,
   input wire logic errorHold,
   input wire logic instrValid,
   input wire logic [7:0] instrErrorField,
   input wire logic instrEnd,
   input wire logic skipEnable,
   input wire logic read_gate_pin,
   input wire logic write_gate_pin,
   input wire logic bufferSource,
   input wire logic read_compare_enable,
   input wire logic segmentAdvance,
   output logic seqBlocked,
   output logic storeLoadValid,
   output logic [7:0] storeLoadData,
   output logic segmentStart,
   output logic segmentReady,
   output logic [7:0] segmentSize,
   output logic [2:0] segmentIndex,
   output logic eccEnable,
   output id_file_pkg::ecc_source_type eccSource,
   output logic skipJump,
   output logic [2:0] skipTarget,
   output logic expectedIsLba,
   output logic [30:0] expectedLba,
   output logic [31:0] expectedChs
);
   import id_file_pkg::*;

   function automatic logic [4:0] fieldBase(input field_type f, input logic copyB, input logic segMode);
      logic [4:0] b;
      b = EXPECTED_BASE;
      unique case (f)
         FIELD_ACTIVE: b = copyB ? (segMode ? SEG_ACTIVE_B_BASE : ACTIVE_B_BASE) : ACTIVE_A_BASE;
         FIELD_SEG_COUNT: b = copyB ? SEG_COUNT_B_BASE : SEG_COUNT_A_BASE;
         default: b = EXPECTED_BASE;
      endcase
      return b;
   endfunction : fieldBase

   logic accessEnable_reg, accessEnable_next;
   logic [4:0] pointer_reg, pointer_next;
   logic [7:0] busReadData_next;
   logic storeLoadValid_next;
   logic [7:0] storeLoadData_next;
   logic seqBlocked_next;
   logic weA, weB;
   logic [4:0] addrA, addrB, rdAddr;
   logic [7:0] dataA, dataB, memData;
   logic [7:0] exp_reg [4];
   logic [7:0] exp_next [4];
   logic expectedIsLba_next;
   logic [30:0] expectedLba_next;
   logic [31:0] expectedChs_next;
   seg_state_type segState_reg, segState_next;
   logic [2:0] settle_reg, settle_next;
   logic [2:0] segIdx_reg, segIdx_next;
   logic fetch_reg, fetch_next;
   logic segmentStart_next, segmentReady_next;
   logic [7:0] segmentSize_next;
   logic eccEnable_next;
   ecc_source_type eccSource_next;
   logic skipJump_next;
   logic [2:0] skipTarget_next;
   logic trigger;

   // Processor register port
   always_comb
   begin
      accessEnable_next = accessEnable_reg;
      pointer_next = pointer_reg;
      busReadData_next = BYTE_RESET;
      storeLoadValid_next = 1'b0;
      storeLoadData_next = storeLoadData;
      if (busWrite && busAddr == POINTER_OFFSET)
      begin
         accessEnable_next = busWriteData[ACCESS_ENABLE_BIT];
         pointer_next = busWriteData[4:0];
      end
      if (busWrite && busAddr == ERROR_FIELD_OFFSET)
      begin
         storeLoadValid_next = 1'b1;
         storeLoadData_next = busWriteData;
      end
      if (busRead && busAddr == POINTER_OFFSET)
      begin
         busReadData_next = {accessEnable_reg, 2'b00, pointer_reg};
      end
      if (busRead && busAddr == DATA_PORT_OFFSET && accessEnable_reg)
      begin
         busReadData_next = memData;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         accessEnable_reg <= ACCESS_ENABLE_RESET;
         pointer_reg <= POINTER_RESET;
         busReadData <= BYTE_RESET;
         storeLoadValid <= 1'b0;
         storeLoadData <= BYTE_RESET;
      end
      else
      begin
         accessEnable_reg <= accessEnable_next;
         pointer_reg <= pointer_next;
         busReadData <= busReadData_next;
         storeLoadValid <= storeLoadValid_next;
         storeLoadData <= storeLoadData_next;
      end
   end

   // File port steering
   always_comb
   begin
      seqBlocked_next = accessEnable_next;
      weA = 1'b0;
      weB = 1'b0;
      addrA = fieldBase(seqField, 1'b0, segmented_sector_mode) + {2'b00, seqIndex};
      addrB = fieldBase(seqField, 1'b1, segmented_sector_mode) + {2'b00, seqIndex};
      dataA = seqData;
      dataB = seqData;
      // Look ahead one index so the count stands when fetched
      rdAddr = SEG_COUNT_A_BASE + {2'b00, segIdx_next};
      if (accessEnable_reg)
      begin
         rdAddr = pointer_reg;
         addrA = pointer_reg;
         dataA = busWriteData;
         weA = busWrite && busAddr == DATA_PORT_OFFSET;
      end
      else if (seqWrite)
      begin
         weA = !(seqField == FIELD_ACTIVE && errorHold);
         weB = seqField != FIELD_EXPECTED && !(seqField == FIELD_ACTIVE && errorHold);
      end
   end

   id_file_mem uMem
   (
      .clock(clock),
      .rst(rst),
      .writeEnA(weA),
      .writeAddrA(addrA),
      .writeDataA(dataA),
      .writeEnB(weB),
      .writeAddrB(addrB),
      .writeDataB(dataB),
      .readAddr(rdAddr),
      .readData(memData)
   );

   // Expected ID shadow
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         exp_next[i] = exp_reg[i];
      end
      if (weA && addrA >= EXPECTED_BASE && addrA <= EXPECTED_LAST)
      begin
         exp_next[addrA[1:0]] = dataA;
      end
      expectedIsLba_next = block_format_select;
      expectedLba_next = {lba_width_select ? exp_next[0][6:0] : 7'h00, exp_next[1], exp_next[2], exp_next[3]};
      expectedChs_next = {exp_next[0], exp_next[1], exp_next[2], exp_next[3]};
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 4; i++)
         begin
            exp_reg[i] <= BYTE_RESET;
         end
         seqBlocked <= ACCESS_ENABLE_RESET;
         expectedIsLba <= 1'b0;
         expectedLba <= 31'h0000_0000;
         expectedChs <= 32'h0000_0000;
      end
      else
      begin
         exp_reg <= exp_next;
         seqBlocked <= seqBlocked_next;
         expectedIsLba <= expectedIsLba_next;
         expectedLba <= expectedLba_next;
         expectedChs <= expectedChs_next;
      end
   end

   // Segmentation engine and instruction fields
   assign trigger = instrValid && segmented_sector_mode && instrErrorField[TRIGGER_BIT];

   always_comb
   begin
      segState_next = segState_reg;
      settle_next = settle_reg;
      segIdx_next = segIdx_reg;
      fetch_next = 1'b0;
      segmentStart_next = 1'b0;
      segmentSize_next = segmentSize;
      if (trigger)
      begin
         segState_next = SEG_PREP;
         settle_next = SETTLE_COUNT;
         segIdx_next = 3'h0;
         segmentStart_next = 1'b1;
      end
      else
      begin
         unique case (segState_reg)
            SEG_IDLE:
            begin
               segIdx_next = 3'h0;
            end
            SEG_PREP:
            begin
               settle_next = settle_reg - 3'h1;
               if (settle_reg == 3'h0)
               begin
                  segState_next = SEG_RUN;
                  fetch_next = 1'b1;
               end
            end
            SEG_RUN:
            begin
               if (segmentAdvance && !accessEnable_reg)
               begin
                  fetch_next = 1'b1;
                  segIdx_next = segIdx_reg + 3'h1;
                  if (segIdx_reg == SEG_COUNT_LAST)
                  begin
                     segState_next = SEG_IDLE;
                     fetch_next = 1'b0;
                  end
               end
            end
         endcase
      end
      if (fetch_reg && !accessEnable_reg)
      begin
         segmentSize_next = memData;
      end
      segmentReady_next = segState_next == SEG_RUN && !fetch_next;
   end

   always_comb
   begin
      eccEnable_next = instrValid && instrErrorField[ECC_BIT];
      eccSource_next = ECC_NONE;
      if (eccEnable_next)
      begin
         if (read_gate_pin && (!read_compare_enable || bufferSource))
         begin
            eccSource_next = ECC_DISK;
         end
         else if (write_gate_pin)
         begin
            eccSource_next = bufferSource ? ECC_FIFO : ECC_IMMEDIATE;
         end
      end
      skipJump_next = 1'b0;
      skipTarget_next = 3'b000;
      if (instrValid && instrEnd && skipEnable && segmented_sector_mode)
      begin
         unique case (instrErrorField[SKIP_SEL_HI:SKIP_SEL_LO])
            SKIP_ONE: skipTarget_next = 3'b001;
            SKIP_TWO: skipTarget_next = 3'b010;
            SKIP_THREE: skipTarget_next = 3'b100;
            default: skipTarget_next = 3'b000;
         endcase
         skipJump_next = skipTarget_next != 3'b000;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         segState_reg <= SEG_IDLE;
         settle_reg <= 3'h0;
         segIdx_reg <= 3'h0;
         fetch_reg <= 1'b0;
         segmentStart <= 1'b0;
         segmentReady <= 1'b0;
         segmentSize <= BYTE_RESET;
         segmentIndex <= 3'h0;
         eccEnable <= 1'b0;
         eccSource <= ECC_NONE;
         skipJump <= 1'b0;
         skipTarget <= 3'b000;
      end
      else
      begin
         segState_reg <= segState_next;
         settle_reg <= settle_next;
         segIdx_reg <= segIdx_next;
         fetch_reg <= fetch_next;
         segmentStart <= segmentStart_next;
         segmentReady <= segmentReady_next;
         segmentSize <= segmentSize_next;
         segmentIndex <= segIdx_next;
         eccEnable <= eccEnable_next;
         eccSource <= eccSource_next;
         skipJump <= skipJump_next;
         skipTarget <= skipTarget_next;
      end
   end

   AST_BLOCK_SEQ: assert property (@(posedge clock) disable iff (rst)
      accessEnable_reg |-> !weB) else $error("sequencer copy write while processor owns file");
   AST_POINTER_SEL: assert property (@(posedge clock) disable iff (rst)
      (accessEnable_reg && busWrite && busAddr == DATA_PORT_OFFSET) |-> (weA && addrA == pointer_reg))
      else $error("data port write missed pointed byte");
   AST_READBACK: assert property (@(posedge clock) disable iff (rst)
      (accessEnable_reg && busRead && busAddr == DATA_PORT_OFFSET) |=> busReadData == $past(memData))
      else $error("data port read wrong byte");
   AST_COPY_B: assert property (@(posedge clock) disable iff (rst)
      (!accessEnable_reg && seqWrite && seqField == FIELD_ACTIVE && !errorHold && !segmented_sector_mode)
      |-> (weA && weB && addrB == addrA + ACTIVE_B_BASE)) else $error("active copies not written together");
   AST_HOLD: assert property (@(posedge clock) disable iff (rst)
      (errorHold && seqField == FIELD_ACTIVE && !accessEnable_reg) |-> !weA && !weB)
      else $error("held active ID overwritten");
   AST_STORE_LOAD: assert property (@(posedge clock) disable iff (rst)
      (busWrite && busAddr == ERROR_FIELD_OFFSET) |=> storeLoadValid && storeLoadData == $past(busWriteData))
      else $error("store byte not presented");
   AST_SETTLE: assert property (@(posedge clock) disable iff (rst)
      (trigger ##1 !trigger [*4]) |-> !segmentReady) else $error("segmentation ready too early");
   AST_READY: assert property (@(posedge clock) disable iff (rst)
      (trigger ##1 (!trigger && !segmentAdvance) [*6]) |-> segmentReady) else $error("segmentation never ready");
   AST_ECC: assert property (@(posedge clock) disable iff (rst)
      (instrValid && instrErrorField[ECC_BIT] && write_gate_pin && !read_gate_pin && bufferSource)
      |=> eccEnable && eccSource == ECC_FIFO) else $error("ECC source not buffer FIFO");
   AST_SKIP: assert property (@(posedge clock) disable iff (rst)
      (instrValid && instrEnd && skipEnable && segmented_sector_mode
      && instrErrorField[SKIP_SEL_HI:SKIP_SEL_LO] == SKIP_TWO) |=> skipJump && skipTarget == 3'b010)
      else $error("skip target two not chosen");
   AST_RESET_OWNER: assert property (@(posedge clock)
      $fell(rst) |-> !accessEnable_reg && !seqBlocked) else $error("processor owns file after reset");
endmodule : id_segment_register_file
`default_nettype wire

/* shared/id_file_pkg.sv */
`default_nettype none
package id_file_pkg;
   // Register offsets on the processor port
   localparam logic [7:0] POINTER_OFFSET = 8'h34;
   localparam logic [7:0] DATA_PORT_OFFSET = 8'h36;
   localparam logic [7:0] ERROR_FIELD_OFFSET = 8'h38;
   // Pointer register layout
   localparam int ACCESS_ENABLE_BIT = 7;
   localparam logic [4:0] POINTER_RESET = 5'h00;
   localparam logic ACCESS_ENABLE_RESET = 1'b0;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // Error field layout
   localparam int TRIGGER_BIT = 7;
   localparam int ECC_BIT = 6;
   localparam int SKIP_SEL_HI = 5;
   localparam int SKIP_SEL_LO = 4;
   // File geometry
   localparam int FILE_DEPTH = 32;
   localparam logic [4:0] ACTIVE_A_BASE = 5'h00;
   localparam logic [4:0] ACTIVE_B_BASE = 5'h0C;
   localparam logic [4:0] SEG_ACTIVE_B_BASE = 5'h04;
   localparam logic [4:0] SEG_COUNT_A_BASE = 5'h08;
   localparam logic [4:0] SEG_COUNT_B_BASE = 5'h10;
   localparam logic [4:0] EXPECTED_BASE = 5'h18;
   localparam logic [4:0] EXPECTED_LAST = 5'h1B;
   localparam logic [2:0] SEG_COUNT_LAST = 3'h7;
   // Settle time after a segmentation trigger, in link reference cycles
   localparam int SETTLE_CYCLES = 4;
   localparam logic [2:0] SETTLE_COUNT = 3'(SETTLE_CYCLES - 1);
   // Skip target select codes
   localparam logic [1:0] SKIP_ONE = 2'b00;
   localparam logic [1:0] SKIP_TWO = 2'b01;
   localparam logic [1:0] SKIP_THREE = 2'b10;
   typedef enum logic [1:0]
   {
      FIELD_ACTIVE = 2'b00,
      FIELD_SEG_COUNT = 2'b01,
      FIELD_EXPECTED = 2'b10
   } field_type;
   typedef enum logic [2:0]
   {
      ECC_NONE = 3'b000,
      ECC_DISK = 3'b001,
      ECC_FIFO = 3'b010,
      ECC_IMMEDIATE = 3'b100
   } ecc_source_type;
   typedef enum logic [2:0]
   {
      SEG_IDLE = 3'b001,
      SEG_PREP = 3'b010,
      SEG_RUN = 3'b100
   } seg_state_type;
endpackage : id_file_pkg
`default_nettype wire

/* hw/id_file_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module id_file_mem
(
   input wire logic clock,
   input wire logic rst,
   input wire logic writeEnA,
   input wire logic [4:0] writeAddrA,
   input wire logic [7:0] writeDataA,
   input wire logic writeEnB,
   input wire logic [4:0] writeAddrB,
   input wire logic [7:0] writeDataB,
   input wire logic [4:0] readAddr,
   output logic [7:0] readData
);
   import id_file_pkg::*;

   logic [7:0] cell_reg [FILE_DEPTH];
   logic [7:0] readData_next;

   always_comb
   begin
      readData_next = cell_reg[readAddr];
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         readData <= BYTE_RESET;
      end
      else
      begin
         readData <= readData_next;
      end
   end

   // One byte cell each; port A wins a same-address collision
   for (genvar i = 0; i < FILE_DEPTH; i++)
   begin : gCell
      logic [7:0] cell_next;
      always_comb
      begin
         cell_next = cell_reg[i];
         if (writeEnB && writeAddrB == 5'(i))
         begin
            cell_next = writeDataB;
         end
         if (writeEnA && writeAddrA == 5'(i))
         begin
            cell_next = writeDataA;
         end
      end
      always_ff @(posedge clock or posedge rst)
      begin
         if (rst)
         begin
            cell_reg[i] <= BYTE_RESET;
         end
         else
         begin
            cell_reg[i] <= cell_next;
         end
      end
   end
endmodule : id_file_mem
`default_nettype wire

/* verif/cpu_port_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cpu_port_model
(
   input wire logic clock,
   output logic [7:0] busAddr,
   output logic [7:0] busWriteData,
   output logic busWrite,
   output logic busRead
);
   initial
   begin
      busAddr = 8'h00;
      busWriteData = 8'h00;
      busWrite = 1'b0;
      busRead = 1'b0;
   end

   // One-cycle strobe, then released lines show scrambled values
   task automatic access(input logic [7:0] addr, input logic [7:0] data, input logic isWrite);
      @(posedge clock);
      busAddr <= addr;
      busWriteData <= data;
      busWrite <= isWrite;
      busRead <= !isWrite;
      @(posedge clock);
      busWrite <= 1'b0;
      busRead <= 1'b0;
      busAddr <= ~addr;
      busWriteData <= ~data;
   endtask : access
endmodule : cpu_port_model
`default_nettype wire

/* verif/id_segment_register_file_test.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, want, what) begin checked++; if ((got) !== (want)) begin numErrors++; $display("unexpected at %0t: %s", $time, what); end end
module id_segment_register_file_test;
   import id_file_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] busAddr, busWriteData, busReadData, seqData, instrErrorField, storeLoadData, segmentSize, want;
   logic busWrite, busRead, segmented_sector_mode, block_format_select, lba_width_select, seqWrite, errorHold;
   logic instrValid, instrEnd, skipEnable, read_gate_pin, write_gate_pin, bufferSource, read_compare_enable;
   logic segmentAdvance, seqBlocked, storeLoadValid, segmentStart, segmentReady, eccEnable, skipJump;
   logic expectedIsLba, enable;
   logic readLate = 1'b0;
   logic [2:0] seqIndex, segmentIndex, skipTarget;
   logic [4:0] ptr;
   logic [30:0] expectedLba;
   logic [31:0] expectedChs;
   logic [31:0] seed = 32'h0000_b5d1;
   field_type seqField;
   ecc_source_type eccSource;
   logic [7:0] mem [FILE_DEPTH];
   logic [7:0] readQ [$];
   logic [7:0] storeQ [$];
   logic [3:0] gateCase [6] = '{4'ha, 4'hb, 4'h6, 4'h4, 4'h0, 4'h8};
   ecc_source_type srcCase [5] = '{ECC_DISK, ECC_DISK, ECC_FIFO, ECC_IMMEDIATE, ECC_NONE};
   int numErrors = 0, checked = 0, cycles = 0, hits;

   always #4 clock = ~clock;

   cpu_port_model cpu (.clock, .busAddr, .busWriteData, .busWrite, .busRead);

   id_segment_register_file DUT
   (
      .clock, .rst, .busAddr, .busWriteData, .busWrite, .busRead, .busReadData,
      .segmented_sector_mode, .block_format_select, .lba_width_select, .seqWrite, .seqField,
      .seqIndex, .seqData, .errorHold, .instrValid, .instrErrorField, .instrEnd, .skipEnable,
      .read_gate_pin, .write_gate_pin, .bufferSource, .read_compare_enable, .segmentAdvance,
      .seqBlocked, .storeLoadValid, .storeLoadData, .segmentStart, .segmentReady, .segmentSize,
      .segmentIndex, .eccEnable, .eccSource, .skipJump, .skipTarget, .expectedIsLba, .expectedLba,
      .expectedChs
   );

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd

   task automatic finishTest();
      $display("comparisons %0d, mismatches %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finishTest

   task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
      if (a == POINTER_OFFSET)
      begin
         ptr = d[4:0];
         enable = d[ACCESS_ENABLE_BIT];
      end
      if (a == DATA_PORT_OFFSET && enable)
         mem[ptr] = d;
      if (a == ERROR_FIELD_OFFSET)
         storeQ.push_back(d);
      cpu.access(a, d, 1'b1);
   endtask : regWrite

   task automatic regRead(input logic [7:0] a);
      if (a == DATA_PORT_OFFSET && enable)
         readQ.push_back(mem[ptr]);
      else if (a == POINTER_OFFSET)
         readQ.push_back({enable, 2'b00, ptr});
      else
         readQ.push_back(8'h00);
      cpu.access(a, rnd(), 1'b0);
   endtask : regRead

   task automatic seqCapture(input field_type f, input int i);
      logic [7:0] d;
      d = rnd();
      // captures refused while processor owns file
      if (!enable && f == FIELD_EXPECTED)
         mem[EXPECTED_BASE + i] = d;
      if (!enable && f == FIELD_SEG_COUNT)
      begin
         mem[SEG_COUNT_A_BASE + i] = d;
         mem[SEG_COUNT_B_BASE + i] = d;
      end
      if (!enable && f == FIELD_ACTIVE && !errorHold)
      begin
         mem[ACTIVE_A_BASE + i] = d;
         mem[(segmented_sector_mode ? SEG_ACTIVE_B_BASE : ACTIVE_B_BASE) + i] = d;
      end
      @(posedge clock);
      seqField <= f;
      seqIndex <= 3'(i);
      seqData <= d;
      seqWrite <= 1'b1;
      @(posedge clock);
      seqWrite <= 1'b0;
   endtask : seqCapture

   task automatic readAll();
      for (int i = 0; i < FILE_DEPTH; i++)
      begin
         regWrite(POINTER_OFFSET, {3'b100, 5'(i)});
         regRead(DATA_PORT_OFFSET);
      end
   endtask : readAll

   task automatic captureAll();
      regWrite(POINTER_OFFSET, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         seqCapture(FIELD_SEG_COUNT, i);
         if (i < 4)
            seqCapture(FIELD_ACTIVE, i);
         if (i < 4)
            seqCapture(FIELD_EXPECTED, i);
      end
      @(posedge clock);
      errorHold <= 1'b1;
      @(negedge clock);
      seqCapture(FIELD_ACTIVE, 1);
      @(posedge clock);
      errorHold <= 1'b0;
      readAll();
   endtask : captureAll

   always @(posedge clock)
   begin
      readLate <= busRead;
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         numErrors++;
         finishTest();
      end
   end

   always @(negedge clock)
   begin
      if (readLate)
      begin
         want = readQ.size() ? readQ.pop_front() : 8'h00;
         `CHECK(busReadData, want, "register read data")
      end
      if (storeLoadValid === 1'b1)
      begin
         want = storeQ.size() ? storeQ.pop_front() : ~storeLoadData;
         `CHECK(storeLoadData, want, "store load byte")
      end
   end

   initial
   begin
      {segmented_sector_mode, block_format_select, lba_width_select, seqWrite, errorHold} = '0;
      {instrValid, instrEnd, skipEnable, read_gate_pin, write_gate_pin, bufferSource} = '0;
      {read_compare_enable, segmentAdvance, seqIndex, seqData, instrErrorField} = '0;
      seqField = FIELD_ACTIVE;
      enable = 1'b0;
      ptr = POINTER_RESET;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      `CHECK(seqBlocked, 1'b0, "owner after reset")
      regRead(DATA_PORT_OFFSET);
      regRead(ERROR_FIELD_OFFSET);
      regRead(8'h3a);
      $display("test done: reset and refused reads");
      for (int i = 0; i < FILE_DEPTH; i++)
      begin
         regWrite(POINTER_OFFSET, {3'b100, 5'(i)});
         regWrite(DATA_PORT_OFFSET, rnd());
      end
      regRead(POINTER_OFFSET);
      @(negedge clock);
      `CHECK(seqBlocked, 1'b1, "processor owns file")
      seqCapture(FIELD_ACTIVE, 0);
      readAll();
      $display("test done: processor file access");
      captureAll();
      @(posedge clock);
      segmented_sector_mode <= 1'b1;
      captureAll();
      $display("test done: captures in both modes");
      for (int m = 0; m < 3; m++)
      begin
         @(posedge clock);
         block_format_select <= (m != 2);
         lba_width_select <= (m == 0);
         repeat (3) @(posedge clock);
         @(negedge clock);
         `CHECK(expectedIsLba, (m != 2), "format select")
         if (m == 2) `CHECK(expectedChs, {mem[24], mem[25], mem[26], mem[27]}, "chs bytes")
         if (m != 2) `CHECK(expectedLba, {((m == 0) ? mem[24][6:0] : 7'h00), mem[25], mem[26], mem[27]}, "lba")
      end
      $display("test done: expected id");
      regWrite(POINTER_OFFSET, 8'h00);
      for (int s = 0; s < 2; s++)
      begin
         hits = 0;
         @(posedge clock);
         segmented_sector_mode <= s[0];
         instrValid <= 1'b1;
         instrErrorField <= 8'h80;
         @(posedge clock);
         instrValid <= 1'b0;
         repeat (10)
         begin
            @(negedge clock);
            hits += (segmentStart === 1'b1);
         end
         `CHECK(hits, s, "segmentation trigger")
      end
      `CHECK(segmentReady, 1'b1, "segment ready")
      `CHECK(segmentSize, mem[SEG_COUNT_A_BASE], "first segment")
      for (int k = 1; k < 4; k++)
      begin
         @(posedge clock);
         segmentAdvance <= 1'b1;
         @(posedge clock);
         segmentAdvance <= 1'b0;
         repeat (3) @(posedge clock);
         @(negedge clock);
         `CHECK(segmentSize, mem[SEG_COUNT_A_BASE + k], "next segment")
         `CHECK(segmentIndex, 3'(k), "segment index")
      end
      $display("test done: segmentation");
      // gates raised in the same cycle as the ECC instruction
      for (int c = 0; c < 6; c++)
      begin
         @(posedge clock);
         {read_gate_pin, write_gate_pin, bufferSource, read_compare_enable} <= gateCase[c];
         instrValid <= 1'b1;
         instrErrorField <= (c == 5) ? 8'h00 : 8'h40;
         repeat (2) @(posedge clock);
         @(negedge clock);
         `CHECK(eccEnable, (c != 5), "ecc enable")
         if (c != 5) `CHECK(eccSource, srcCase[c], "ecc source")
      end
      $display("test done: ecc");
      for (int c = 0; c < 4; c++)
      begin
         @(posedge clock);
         {read_gate_pin, write_gate_pin} <= 2'b00;
         skipEnable <= 1'b1;
         instrErrorField <= {2'b00, 2'(c), 4'h0};
         instrEnd <= 1'b1;
         @(posedge clock);
         instrEnd <= 1'b0;
         @(negedge clock);
         `CHECK(skipJump, (c != 3), "skip jump")
         if (c != 3) `CHECK(skipTarget, 3'(1 << c), "skip target")
      end
      $display("test done: skip select");
      regWrite(ERROR_FIELD_OFFSET, rnd());
      regWrite(ERROR_FIELD_OFFSET, rnd());
      repeat (3) @(posedge clock);
      `CHECK(storeQ.size(), 0, "store loads seen")
      $display("test done: store load");
      regWrite(POINTER_OFFSET, 8'h85);
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      enable = 1'b0;
      ptr = POINTER_RESET;
      @(negedge clock);
      `CHECK(seqBlocked, 1'b0, "owner after second reset")
      regRead(DATA_PORT_OFFSET);
      repeat (3) @(posedge clock);
      $display("test done: mid-run reset");
      finishTest();
   end
endmodule : id_segment_register_file_test
`default_nettype wire
